// >>> pkg/mph_pkg.sv
// Shared constants and types for the motor preheat controller
package mph_pkg;
	// ========================================================
	// Activation source selection
	typedef enum logic [2:0] {
		MPH_SRC_NONE,
		MPH_SRC_CONT,
		MPH_SRC_TEMP,
		MPH_SRC_DIN,
		MPH_SRC_LINE
	} mph_src_t;

	// ========================================================
	// Widths
	localparam int TEMP_W     = 12;
	localparam int LEVEL_W    = 7;
	localparam int RESTART_W  = 10;
	localparam int PREHEAT_W  = 10;

	// ========================================================
	// Time base
	localparam int CLK_HZ          = 100_000_000;
	localparam int TICK_S          = 1;
	localparam int TICK_CYCLES     = CLK_HZ * TICK_S;
	localparam int SEC_PER_MIN     = 60;

	// ========================================================
	// Preheat current level, percent of nominal motor current
	localparam logic [LEVEL_W-1:0] LEVEL_RST = 7'h05;
	localparam logic [LEVEL_W-1:0] LEVEL_MIN = 7'h05;
	localparam logic [LEVEL_W-1:0] LEVEL_MAX = 7'h46;
endpackage

// >>> hw/mph_delay_timer.sv
// Down counter for one delay, stepped by a slow tick
`timescale 1ns/1ps
module mph_delay_timer #(
	parameter int W = 10
) (
	input  wire logic         mclk_in,
	input  wire logic         rst_in,
	input  wire logic         load_in,
	input  wire logic [W-1:0] value_in,
	input  wire logic         tick_in,
	output logic              done_out
);
	logic [W-1:0] count_r;
	logic [W-1:0] count_nxt;

	generate
		if (W < 1) begin : g_chk
			$error("mph_delay_timer: W must be at least 1");
		end
	endgenerate

	// ========================================================
	// Count
	assign count_nxt = load_in ? value_in :
		(tick_in && count_r != '0) ? count_r - W'(1) : count_r;

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			count_r <= '0;
		end else begin
			count_r <= count_nxt;
		end
	end

	assign done_out = (count_r == '0) && !load_in;
endmodule

// >>> hw/mph_ctrl.sv
// Motor preheat controller: activation, delays and status
//
// Function
// R1: Continuous mode preheats whenever the starter is ready.
// R2: Temperature mode starts when ready and temperature below low threshold.
// R3: Temperature mode ends above high threshold or on a Stop order.
// R4: Input mode starts only while assigned input high and motor stopped.
// R5: Preheat takes effect only after restart and preheat delays expire.
// R6: Status shows preheat ordered, even while restart delay still runs.
// R7: Continuous mode ends on a Stop order.
// R8: Terminal stop in two-wire control cannot end preheating.
// R9: Input mode ends on input low while ready, or Stop order.
// R10: Preheat delay starts counting when the motor becomes stopped.
// R11: Operator holds run input and assigned preheat input high to start.
// R12: Input mode also ends on a Run order.
// R13: Both delays run concurrently from the stop event, never added.
// R14: Fieldbus master keeps Halt active to stay in operating state 5.
// R15: Preheat current adjustable in percent of nominal, default five.
// R16: Motor thermal monitoring suspended while preheating is active.
// R17: Independent delay counters, restart on the second tick and preheat on the minute tick, reloaded on stop.
`timescale 1ns/1ps
module mph_ctrl #(
	parameter int TICK_CYCLES = mph_pkg::TICK_CYCLES
) (
	input  wire logic                          mclk_in,
	input  wire logic                          rst_in,
	input  wire logic [2:0]                    preheat_source_select_in,
	input  wire logic                          ready_in,
	input  wire logic                          motor_stopped_in,
	input  wire logic                          stop_order_in,
	input  wire logic                          run_order_in,
	input  wire logic                          two_wire_ctrl_in,
	input  wire logic                          terminal_stop_in,
	input  wire logic                          assigned_digital_input_in,
	input  wire logic                          line_channel_bit_in,
	input  wire logic signed [mph_pkg::TEMP_W-1:0] temp_meas_in,
	input  wire logic signed [mph_pkg::TEMP_W-1:0] temp_low_threshold_in,
	input  wire logic signed [mph_pkg::TEMP_W-1:0] temp_high_threshold_in,
	input  wire logic [mph_pkg::RESTART_W-1:0] restart_delay_in,
	input  wire logic [mph_pkg::PREHEAT_W-1:0] preheat_delay_in,
	input  wire logic [mph_pkg::LEVEL_W-1:0]   preheat_current_level_in,
	output logic                               preheat_active_status_out,
	output logic                               preheat_inject_out,
	output logic                               thermal_monitor_hold_out,
	output logic [mph_pkg::LEVEL_W-1:0]        preheat_current_level_out,
	output logic                               restart_delay_done_out,
	output logic                               preheat_delay_done_out
);
	localparam int TICK_W = $clog2(TICK_CYCLES + 1);
	localparam int MIN_W  = $clog2(mph_pkg::SEC_PER_MIN + 1);

	generate
		if (TICK_CYCLES < 1) begin : g_chk
			$error("mph_ctrl: TICK_CYCLES must be at least 1");
		end
	endgenerate

	// ========================================================
	// Pin synchronisers
	logic [1:0] din_sync_r;
	logic [1:0] tstop_sync_r;
	logic       din_lvl;
	logic       tstop_lvl;

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			din_sync_r   <= 2'h0;
			tstop_sync_r <= 2'h0;
		end else begin
			din_sync_r   <= {din_sync_r[0], assigned_digital_input_in};
			tstop_sync_r <= {tstop_sync_r[0], terminal_stop_in};
		end
	end

	assign din_lvl   = din_sync_r[1];
	assign tstop_lvl = tstop_sync_r[1];

	// ========================================================
	// Slow time base: one second and one minute ticks
	logic [TICK_W-1:0] tick_cnt_r;
	logic [MIN_W-1:0]  min_cnt_r;
	logic              sec_tick;
	logic              min_tick;

	assign sec_tick = (tick_cnt_r == TICK_W'(TICK_CYCLES - 1));
	assign min_tick = sec_tick &&
		(min_cnt_r == MIN_W'(mph_pkg::SEC_PER_MIN - 1));

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			tick_cnt_r <= '0;
			min_cnt_r  <= '0;
		end else begin
			tick_cnt_r <= sec_tick ? '0 : tick_cnt_r + TICK_W'(1);
			if (min_tick) begin
				min_cnt_r <= '0;
			end else if (sec_tick) begin
				min_cnt_r <= min_cnt_r + MIN_W'(1);
			end
		end
	end

	// ========================================================
	// Stop event and delays
	logic stopped_d_r;
	logic stop_event;
	logic restart_done;
	logic preheat_done;

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			stopped_d_r <= 1'b1;
		end else begin
			stopped_d_r <= motor_stopped_in;
		end
	end

	// Both timers load on the same edge so the delays overlap
	assign stop_event = motor_stopped_in && !stopped_d_r; // R10 R13

	mph_delay_timer #(
		.W(mph_pkg::RESTART_W)
	) u_restart (
		.mclk_in  (mclk_in),
		.rst_in   (rst_in),
		.load_in  (stop_event),
		.value_in (restart_delay_in),
		.tick_in  (sec_tick),
		.done_out (restart_done)
	); // R17

	mph_delay_timer #(
		.W(mph_pkg::PREHEAT_W)
	) u_preheat (
		.mclk_in  (mclk_in),
		.rst_in   (rst_in),
		.load_in  (stop_event),
		.value_in (preheat_delay_in),
		.tick_in  (min_tick),
		.done_out (preheat_done)
	); // R17

	// ========================================================
	// Activation decode
	mph_pkg::mph_src_t src;
	logic              stop_any;
	logic              in_lvl;
	logic              is_input_mode;
	logic              temp_low;
	logic              temp_high;
	logic              start_req;
	logic              end_req;

	assign src = mph_pkg::mph_src_t'(preheat_source_select_in);

	// Terminal stop is ignored in two-wire: the run wire owns it
	assign stop_any = stop_order_in ||
		(tstop_lvl && !two_wire_ctrl_in); // R8

	assign is_input_mode = (src == mph_pkg::MPH_SRC_DIN) ||
		(src == mph_pkg::MPH_SRC_LINE);
	// Line bit comes from local logic, no sync needed
	assign in_lvl = (src == mph_pkg::MPH_SRC_DIN) ? din_lvl :
		line_channel_bit_in;

	assign temp_low  = temp_meas_in < temp_low_threshold_in;
	assign temp_high = temp_meas_in > temp_high_threshold_in;

	always_comb begin
		start_req = 1'b0;
		end_req   = 1'b0;
		case (src)
			mph_pkg::MPH_SRC_CONT: begin
				start_req = ready_in; // R1
				end_req   = stop_any; // R7
			end
			mph_pkg::MPH_SRC_TEMP: begin
				start_req = ready_in && temp_low; // R2
				end_req   = temp_high || stop_any; // R3
			end
			mph_pkg::MPH_SRC_DIN,
			mph_pkg::MPH_SRC_LINE: begin
				start_req = in_lvl && motor_stopped_in; // R4 R11
				end_req   = (!in_lvl && ready_in) || stop_any ||
					run_order_in; // R9 R12
			end
			default: begin
				start_req = 1'b0;
				end_req   = 1'b1;
			end
		endcase
	end

	// ========================================================
	// Order latch
	// A Stop order blocks restart until the start cause drops away,
	// otherwise continuous mode would rearm on the very next cycle.
	// A Run in input mode blocks too, or a held input would rearm.
	logic ordered_r;
	logic ordered_nxt;
	logic blocked_r;
	logic blocked_nxt;
	logic run_end;

	assign run_end = is_input_mode && run_order_in; // R12
	assign ordered_nxt = end_req ? 1'b0 :
		(start_req && !blocked_r) ? 1'b1 : ordered_r;
	assign blocked_nxt = (stop_any || run_end) ? 1'b1 :
		!start_req ? 1'b0 : blocked_r;

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			ordered_r <= 1'b0;
			blocked_r <= 1'b0;
		end else begin
			ordered_r <= ordered_nxt;
			blocked_r <= blocked_nxt;
		end
	end

	// ========================================================
	// Outputs
	logic inject_nxt;
	logic [mph_pkg::LEVEL_W-1:0] level_nxt;

	// Input mode needs standstill; other modes trust the delays
	assign inject_nxt = ordered_r && restart_done && preheat_done &&
		(motor_stopped_in || !is_input_mode); // R5

	assign level_nxt =
		(preheat_current_level_in < mph_pkg::LEVEL_MIN) ?
			mph_pkg::LEVEL_MIN :
		(preheat_current_level_in > mph_pkg::LEVEL_MAX) ?
			mph_pkg::LEVEL_MAX : preheat_current_level_in; // R15

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			preheat_active_status_out <= 1'b0;
			preheat_inject_out        <= 1'b0;
			thermal_monitor_hold_out  <= 1'b0;
			preheat_current_level_out <= mph_pkg::LEVEL_RST; // R15
			restart_delay_done_out    <= 1'b1;
			preheat_delay_done_out    <= 1'b1;
		end else begin
			preheat_active_status_out <= ordered_r; // R6
			preheat_inject_out        <= inject_nxt; // R5
			thermal_monitor_hold_out  <= inject_nxt; // R16
			preheat_current_level_out <= level_nxt; // R15
			restart_delay_done_out    <= restart_done;
			preheat_delay_done_out    <= preheat_done;
		end
	end
endmodule

// >>> tb/mph_operator.sv
// Operator model: run input and assigned preheat input
`timescale 1ns/1ps
module mph_operator (
	input  wire logic run_hold_in,
	input  wire logic preheat_hold_in,
	output logic      terminal_stop_out,
	output logic      assigned_digital_input_out
);
	// Releasing the run input is the terminal stop
	assign terminal_stop_out = !run_hold_in;
	assign assigned_digital_input_out = preheat_hold_in;
endmodule

// >>> tb/mph_ctrl_properties.sv
// Concurrent checks on the preheat controller ports
`timescale 1ns/1ps
module mph_ctrl_properties (
	input wire logic                        mclk_in,
	input wire logic                        rst_in,
	input wire logic [2:0]                  preheat_source_select_in,
	input wire logic                        ready_in,
	input wire logic                        motor_stopped_in,
	input wire logic                        stop_order_in,
	input wire logic                        run_order_in,
	input wire logic [mph_pkg::LEVEL_W-1:0] preheat_current_level_in,
	input wire logic                        preheat_active_status_out,
	input wire logic                        preheat_inject_out,
	input wire logic                        thermal_monitor_hold_out,
	input wire logic [mph_pkg::LEVEL_W-1:0] preheat_current_level_out,
	input wire logic                        restart_delay_done_out,
	input wire logic                        preheat_delay_done_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	// ========================================================
	// Properties
	a_hold_eq_inject: assert property (
		thermal_monitor_hold_out == preheat_inject_out)
		else $error("thermal hold differs from injection");
	a_inject_delays: assert property (
		preheat_inject_out |-> restart_delay_done_out && preheat_delay_done_out)
		else $error("injection before delays elapsed");
	a_level_pass: assert property (
		(preheat_current_level_in >= mph_pkg::LEVEL_MIN &&
		 preheat_current_level_in <= mph_pkg::LEVEL_MAX) |=>
		preheat_current_level_out == $past(preheat_current_level_in))
		else $error("level in range not passed through");
	a_cont_start: assert property (
		!ready_in ##1 (preheat_source_select_in == mph_pkg::MPH_SRC_CONT &&
		ready_in && !stop_order_in)[*2] |=> preheat_active_status_out)
		else $error("continuous preheat did not start");
	a_stop_ends: assert property (
		stop_order_in |-> ##2 !preheat_active_status_out)
		else $error("stop order did not end preheat");
	a_run_ends: assert property (
		run_order_in && preheat_source_select_in == mph_pkg::MPH_SRC_DIN
		|-> ##2 !preheat_active_status_out)
		else $error("run order did not end input preheat");
	a_din_stopped: assert property (
		preheat_inject_out && $past(preheat_source_select_in) ==
		mph_pkg::MPH_SRC_DIN |-> $past(motor_stopped_in))
		else $error("input mode injected with motor running");
	a_delay_load: assert property (
		$rose(motor_stopped_in) |=>
		!restart_delay_done_out && !preheat_delay_done_out)
		else $error("delays not loaded together on stop");
	c_inject: cover property (preheat_inject_out);
	c_status_fall: cover property ($fell(preheat_active_status_out));
	c_delay_done: cover property ($rose(preheat_delay_done_out));
endmodule

// >>> tb/mph_ctrl_tb.sv
// Self-checking bench for the motor preheat controller
`timescale 1ns/1ps
module mph_ctrl_tb;
	// ========================================================
	// Signals
	logic mclk_in = 0, rst_in = 1, ready_in = 0, motor_stopped_in = 0;
	logic stop_order_in = 0, run_order_in = 0, two_wire_ctrl_in = 0;
	logic line_channel_bit_in = 0, run_hold = 1, preheat_hold = 0;
	logic terminal_stop_in, assigned_digital_input_in;
	logic [2:0] preheat_source_select_in = 3'h0;
	logic signed [mph_pkg::TEMP_W-1:0] temp_meas_in = 12'h0060;
	logic signed [mph_pkg::TEMP_W-1:0] temp_low_threshold_in = 12'h0040;
	logic signed [mph_pkg::TEMP_W-1:0] temp_high_threshold_in = 12'h0080;
	logic [mph_pkg::RESTART_W-1:0] restart_delay_in = 10'h032;
	logic [mph_pkg::PREHEAT_W-1:0] preheat_delay_in = 10'h001;
	logic [mph_pkg::LEVEL_W-1:0] preheat_current_level_in = 7'h03;
	logic [mph_pkg::LEVEL_W-1:0] preheat_current_level_out;
	logic preheat_active_status_out, preheat_inject_out;
	logic thermal_monitor_hold_out, restart_delay_done_out;
	logic preheat_delay_done_out;
	wire logic [2:0] o3 = {preheat_active_status_out, preheat_inject_out,
		thermal_monitor_hold_out};
	wire logic [1:0] dn = {restart_delay_done_out, preheat_delay_done_out};
	int n_errors = 0, cmp_count = 0;
	always #5 mclk_in = ~mclk_in;
	// Short tick keeps the minute delay to 240 cycles
	mph_ctrl #(.TICK_CYCLES(4)) uut (.mclk_in, .rst_in,
		.preheat_source_select_in, .ready_in, .motor_stopped_in,
		.stop_order_in, .run_order_in, .two_wire_ctrl_in, .terminal_stop_in,
		.assigned_digital_input_in, .line_channel_bit_in, .temp_meas_in,
		.temp_low_threshold_in, .temp_high_threshold_in, .restart_delay_in,
		.preheat_delay_in, .preheat_current_level_in,
		.preheat_active_status_out, .preheat_inject_out,
		.thermal_monitor_hold_out, .preheat_current_level_out,
		.restart_delay_done_out, .preheat_delay_done_out);
	mph_operator u_op (.run_hold_in(run_hold), .preheat_hold_in(preheat_hold),
		.terminal_stop_out(terminal_stop_in),
		.assigned_digital_input_out(assigned_digital_input_in));
	// ========================================================
	// Tasks
	task automatic tick(input int n);
		repeat (n) @(negedge mclk_in);
	endtask
	task automatic chk(input logic [6:0] got, input logic [6:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic pulse_stop();
		stop_order_in = 1;
		tick(1);
		stop_order_in = 0;
		tick(3);
	endtask
	task automatic final_report();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#20000;
		n_errors++;
		final_report();
	end
	// ========================================================
	// Tests
	initial begin
		tick(2);
		rst_in = 0;
		chk(preheat_current_level_out, mph_pkg::LEVEL_RST);
		chk({o3, dn}, 7'h03);
		preheat_current_level_in = 7'h50;
		tick(2);
		chk(preheat_current_level_out, mph_pkg::LEVEL_MAX);
		preheat_current_level_in = 7'h20;
		preheat_source_select_in = mph_pkg::MPH_SRC_CONT;
		ready_in = 1;
		tick(3);
		chk(o3, 3'h7);
		pulse_stop();
		chk(o3, 3'h0);
		two_wire_ctrl_in = 1;
		ready_in = 0;
		tick(1);
		ready_in = 1;
		tick(3);
		run_hold = 0;
		tick(5);
		chk(o3, 3'h7);
		run_hold = 1;
		ready_in = 0;
		tick(1);
		ready_in = 1;
		motor_stopped_in = 1;
		tick(150);
		chk({preheat_active_status_out, preheat_inject_out}, 2'h2);
		chk(dn, 2'h0);
		tick(110);
		chk(dn, 2'h3);
		chk(o3, 3'h7);
		pulse_stop();
		preheat_source_select_in = mph_pkg::MPH_SRC_TEMP;
		tick(4);
		chk(o3, 3'h0);
		temp_meas_in = 12'h0020;
		tick(4);
		chk(o3, 3'h7);
		temp_meas_in = 12'h0060;
		tick(4);
		chk(o3, 3'h7);
		temp_meas_in = 12'h0100;
		tick(4);
		chk(o3, 3'h0);
		preheat_source_select_in = mph_pkg::MPH_SRC_DIN;
		preheat_hold = 1;
		tick(6);
		chk(o3, 3'h7);
		preheat_hold = 0;
		tick(6);
		chk(o3, 3'h0);
		preheat_hold = 1;
		tick(6);
		run_order_in = 1;
		tick(1);
		run_order_in = 0;
		tick(3);
		chk(o3, 3'h0);
		preheat_hold = 0;
		tick(4);
		preheat_hold = 1;
		tick(6);
		motor_stopped_in = 0;
		tick(4);
		chk(preheat_inject_out, 1'b0);
		pulse_stop();
		chk(preheat_active_status_out, 1'b0);
		preheat_source_select_in = mph_pkg::MPH_SRC_LINE;
		motor_stopped_in = 1;
		line_channel_bit_in = 1;
		tick(4);
		chk(preheat_active_status_out, 1'b1);
		chk(preheat_inject_out, 1'b0);
		line_channel_bit_in = 0;
		tick(4);
		chk(preheat_active_status_out, 1'b0);
		final_report();
	end
endmodule
bind mph_ctrl mph_ctrl_properties u_props (.mclk_in, .rst_in,
	.preheat_source_select_in, .ready_in, .motor_stopped_in, .stop_order_in,
	.run_order_in, .preheat_current_level_in, .preheat_active_status_out,
	.preheat_inject_out, .thermal_monitor_hold_out,
	.preheat_current_level_out, .restart_delay_done_out,
	.preheat_delay_done_out);
